// *** design/cih_chem_hold.sv ***
// Inject request / hold handshake for one washer controller.
// Assumes program issues a one-cycle go with chemical mask and seconds.
`timescale 1ns/1ps
`default_nettype none
module cih_chem_hold
  import cih_pkg::*;
#(
  parameter int unsigned NCHEM = CHEM_COUNT,
  parameter int unsigned TICKS = TICKS_PER_S
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic inject_go,
  input wire logic [NCHEM-1:0] chem_mask,
  input wire logic [DUR_W-1:0] inject_secs,
  input wire logic dispenser_hold,
  output logic inject_request,
  output logic [NCHEM-1:0] chemical_start_outputs,
  output logic step_timer_run,
  output logic inject_busy
);
  // Refuse sizes the timebase and the checks cannot serve
  if (NCHEM < 1 || TICKS < 2 || TICKS > 32'h7fff_ffff) begin : g_bad_param
    $error("cih_chem_hold: bad parameter");
  end

  logic rst_s1, rst_s2;
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_s1 <= 1'b0;
      rst_s2 <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_s2 <= rst_s1;
    end
  end
  wire logic rst_n = rst_s2;

  // Hold is an external contact; two flops before use
  logic hold_s1, hold_s2;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      hold_s1 <= 1'b0;
      hold_s2 <= 1'b0;
    end else begin
      hold_s1 <= dispenser_hold; // R10
      hold_s2 <= hold_s1;
    end
  end

  cih_state_t state, next_state;
  logic [31:0] tick, next_tick;
  logic [DUR_W-1:0] secs, next_secs;
  logic [DUR_W-1:0] dur, next_dur;
  logic [NCHEM-1:0] mask, next_mask;
  logic [NCHEM-1:0] start_q, next_start;
  logic sec_pulse;

  // Seconds timebase restarts on each phase entry
  assign sec_pulse = (tick == 32'(TICKS - 1)); // R10

  // Last tick of a two-second phase; shared by window and release
  function automatic logic two_s_done(input logic pulse,
                                      input logic [DUR_W-1:0] count);
    return pulse && count == DUR_W'(WINDOW_S - 1);
  endfunction

  always_comb begin
    next_state = state;
    next_tick = sec_pulse ? 32'h0000_0000 : tick + 32'h0000_0001;
    next_secs = sec_pulse ? secs + DUR_W'(1) : secs;
    next_dur = dur;
    next_mask = mask;
    next_start = '0;
    case (state)
      CIH_IDLE: begin
        next_tick = '0;
        next_secs = '0;
        if (inject_go && chem_mask != '0 && inject_secs != '0) begin
          next_state = CIH_WINDOW;
          next_mask = chem_mask;
          next_dur = inject_secs;
        end
      end
      CIH_WINDOW: begin
        if (hold_s2) begin // R7
          next_state = CIH_HOLD;
          next_tick = '0;
          next_secs = '0;
        end else if (two_s_done(sec_pulse, secs)) begin
          next_state = CIH_INJECT; // R4
          next_secs = '0;
          next_start = mask;
        end
      end
      CIH_HOLD: begin
        next_tick = '0;
        next_secs = '0;
        if (!hold_s2) next_state = CIH_RELEASE;
      end
      CIH_RELEASE: begin
        if (two_s_done(sec_pulse, secs)) begin
          next_state = CIH_INJECT; // R5
          next_secs = '0;
          next_start = mask;
        end
      end
      CIH_INJECT: begin
        next_start = mask;
        if (sec_pulse && secs == dur - DUR_W'(1)) begin
          next_state = CIH_IDLE; // R6
          next_start = '0;
        end
      end
      default: next_state = CIH_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= CIH_IDLE;
      tick <= '0;
      secs <= '0;
      dur <= '0;
      mask <= '0;
      start_q <= '0;
    end else begin
      state <= next_state;
      tick <= next_tick;
      secs <= next_secs;
      dur <= next_dur;
      mask <= next_mask;
      start_q <= next_start;
    end
  end

  // Request covers all phases until injection ends
  assign inject_request = (state != CIH_IDLE); // R1 R10
  assign chemical_start_outputs = start_q; // R3
  // Timer also paused during the post-hold delay for a clean resume
  assign step_timer_run = (state != CIH_HOLD) && (state != CIH_RELEASE); // R3
  assign inject_busy = inject_request;

  // Cycles spent in the present state; only the checks read it
  logic [31:0] phase_cycles, next_phase_cycles;
  always_comb begin
    next_phase_cycles = phase_cycles + 32'h0000_0001;
    if (next_state != state) next_phase_cycles = '0;
  end
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_cycles <= '0;
    end else begin
      phase_cycles <= next_phase_cycles;
    end
  end

  // Hold and start gating
  a_hold_blocks_start: assert property ( // R3
    @(posedge sys_clk) disable iff (!rst_n)
    state == CIH_HOLD |-> chemical_start_outputs == '0 && !step_timer_run)
    else $error("start active during hold");
  a_start_needs_req: assert property ( // R1
    @(posedge sys_clk) disable iff (!rst_n)
    chemical_start_outputs != '0 |-> inject_request)
    else $error("start without request");
  a_timer_runs_inject: assert property ( // R5
    @(posedge sys_clk) disable iff (!rst_n)
    state == CIH_INJECT |-> step_timer_run)
    else $error("timer stopped during injection");

  // A hold is only taken in the first two seconds
  a_late_hold_ignored: assert property ( // R7
    @(posedge sys_clk) disable iff (!rst_n)
    state == CIH_INJECT && hold_s2 |=> state != CIH_HOLD)
    else $error("late hold honoured");
  a_hold_from_window: assert property ( // R7
    @(posedge sys_clk) disable iff (!rst_n)
    state == CIH_HOLD && $past(state) != CIH_HOLD |->
    $past(state) == CIH_WINDOW)
    else $error("hold entered outside window");

  // Two-second delays, counted in clock cycles
  a_window_goes_inject: assert property ( // R4
    @(posedge sys_clk) disable iff (!rst_n)
    state == CIH_WINDOW && !hold_s2 && two_s_done(sec_pulse, secs)
    |=> chemical_start_outputs == mask)
    else $error("start missing after window");
  a_window_two_s: assert property ( // R4
    @(posedge sys_clk) disable iff (!rst_n)
    state == CIH_WINDOW && next_state == CIH_INJECT |->
    phase_cycles == 32'(2 * TICKS - 1))
    else $error("window not two seconds");
  a_release_delay: assert property ( // R5
    @(posedge sys_clk) disable iff (!rst_n)
    state == CIH_HOLD && !hold_s2 |=> state == CIH_RELEASE ##1
    chemical_start_outputs == '0)
    else $error("start too soon after release");
  a_release_two_s: assert property ( // R5
    @(posedge sys_clk) disable iff (!rst_n)
    state == CIH_RELEASE && next_state == CIH_INJECT |->
    phase_cycles == 32'(2 * TICKS - 1))
    else $error("release delay not two seconds");

  // Injection length and end of request
  a_start_steady: assert property ( // R6
    @(posedge sys_clk) disable iff (!rst_n)
    chemical_start_outputs != '0 && $past(chemical_start_outputs) != '0
    |-> $stable(chemical_start_outputs))
    else $error("start changed mid injection");
  a_start_ends_idle: assert property ( // R6 R10
    @(posedge sys_clk) disable iff (!rst_n)
    $fell(inject_request) |-> chemical_start_outputs == '0)
    else $error("start outlived request");
  a_request_drops: assert property ( // R10
    @(posedge sys_clk) disable iff (!rst_n)
    state == CIH_INJECT && next_state == CIH_IDLE |=>
    !inject_request && chemical_start_outputs == '0)
    else $error("request kept after injection");

  c_no_hold: cover property (
    @(posedge sys_clk) disable iff (!rst_n)
    state == CIH_WINDOW ##1 state == CIH_INJECT);
  c_hold: cover property (
    @(posedge sys_clk) disable iff (!rst_n)
    state == CIH_RELEASE ##1 state == CIH_INJECT);
  c_done: cover property (
    @(posedge sys_clk) disable iff (!rst_n)
    state == CIH_INJECT ##1 state == CIH_IDLE);
  c_late_hold: cover property (
    @(posedge sys_clk) disable iff (!rst_n)
    state == CIH_INJECT && hold_s2);
endmodule
`default_nettype wire

// *** inc/cih_pkg.sv ***
// Constants for the shared dispenser hold handshake.
// Assumes a single 50 MHz system clock; no software registers.
// Functional notes
// R1: One shared inject request for any chemical
// R2: Dispenser must assert hold within two seconds
// R3: Honoured hold stops timer, starts stay off
// R4: No hold: starts begin two seconds after request
// R5: Hold released: wait two seconds, then start
// R6: Starts last exactly the programmed duration
// R7: Hold ignored outside two-second window after request
// R8: Dispenser arbitrates among machines using hold
// R9: Dispenser copes with multi-chemical requests
// R10: Synchronise hold, seconds timebase, drop request after
package cih_pkg;
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned WINDOW_S = 2;
  localparam int unsigned TICKS_PER_S = CLK_HZ;
  localparam int unsigned CHEM_COUNT = 8;
  localparam int unsigned DUR_W = 16;
  typedef enum logic [2:0] {
    CIH_IDLE, CIH_WINDOW, CIH_HOLD, CIH_RELEASE, CIH_INJECT
  } cih_state_t;
endpackage

// *** tb/cih_disp_model.sv ***
// Dispenser model: holds the machine off after its request.
// Assumes the bench sets hold_at (0 = never) and hold_len.
`timescale 1ns/1ps
`default_nettype none
module cih_disp_model (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic inject_request,
  input wire logic [7:0] hold_at,
  input wire logic [7:0] hold_len,
  output logic dispenser_hold
);
  logic [8:0] cnt;
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt <= 9'h000;
      dispenser_hold <= 1'b0;
    end else begin
      cnt <= inject_request ? cnt + 9'h001 : 9'h000;
      // Serving order is set by when hold rises; any mask is accepted
      dispenser_hold <= inject_request && hold_at != 8'h00 &&
        cnt >= {1'b0, hold_at} &&
        cnt < {1'b0, hold_at} + {1'b0, hold_len};
    end
  end
endmodule
`default_nettype wire

// *** tb/test_cih_chem_hold.sv ***
// Bench for the request/hold handshake: corner and random cases.
// Assumes the dispenser model and a ten-cycle second.
`timescale 1ns/1ps
`default_nettype none
module test_cih_chem_hold;
  import cih_pkg::*;
  localparam int unsigned TK = 10;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic inject_go = 1'b0;
  logic [7:0] chem_mask = 8'h00, hold_at = 8'h00, hold_len = 8'h00;
  logic [DUR_W-1:0] inject_secs = 16'h0000;
  logic dispenser_hold, inject_request, step_timer_run, inject_busy;
  logic [7:0] chemical_start_outputs;
  int n_mismatch = 0, compares = 0, cyc = 0;
  cih_chem_hold #(.NCHEM(8), .TICKS(TK)) u_cih_chem_hold (
    .sys_clk(sys_clk), .rst_b(rst_b), .inject_go(inject_go),
    .chem_mask(chem_mask), .inject_secs(inject_secs),
    .dispenser_hold(dispenser_hold), .inject_request(inject_request),
    .chemical_start_outputs(chemical_start_outputs),
    .step_timer_run(step_timer_run), .inject_busy(inject_busy));
  cih_disp_model u_cih_disp_model (.sys_clk(sys_clk), .rst_b(rst_b),
    .inject_request(inject_request), .hold_at(hold_at),
    .hold_len(hold_len), .dispenser_hold(dispenser_hold));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // A hold_at of 1 to 16 cycles after the request sits inside the window
  function automatic logic honoured(input logic [7:0] ha);
    return ha != 8'h00 && ha <= 8'h10;
  endfunction
  function automatic int exp_wait(input logic hon, input logic [7:0] ha,
                                  input logic [7:0] hl);
    return hon ? int'(ha) + int'(hl) + 2 * TK : 2 * TK;
  endfunction
  task automatic run(input logic [7:0] m, input logic [15:0] s,
                     input logic [7:0] ha, input logic [7:0] hl);
    int n;
    int lo;
    logic stop;
    logic hon;
    n = 0;
    stop = 1'b0;
    hon = honoured(ha);
    lo = exp_wait(hon, ha, hl);
    @(posedge sys_clk);
    hold_at <= ha;
    hold_len <= hl;
    chem_mask <= m;
    inject_secs <= s;
    inject_go <= 1'b1;
    @(posedge sys_clk);
    inject_go <= 1'b0;
    #1 chk(inject_request, 1);
    chk(inject_busy, 1);
    while (chemical_start_outputs === 8'h00 && n < 400) begin
      if (step_timer_run === 1'b0)
        stop = 1'b1;
      @(posedge sys_clk);
      // A second go while busy must change nothing
      inject_go <= (n == 2);
      chem_mask <= (n == 2) ? ~m : m;
      #1 n++;
    end
    chk(n >= lo && n <= lo + (hon ? 5 : 0), 1);
    chk(stop, hon);
    chk(chemical_start_outputs, m);
    chk(step_timer_run, 1);
    n = 0;
    stop = 1'b0;
    while (chemical_start_outputs !== 8'h00 && n < 400) begin
      // A hold arriving late must not stop the timer
      if (step_timer_run !== 1'b1)
        stop = 1'b1;
      @(posedge sys_clk);
      #1 n++;
    end
    chk(n, s * TK);
    chk(stop, 0);
    chk(inject_request, 0);
    chk(inject_busy, 0);
    $display("test done mask %0h hold %0d", m, ha);
  endtask
  initial begin
    forever #10 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_mismatch++;
      end_sim();
    end
  end
  initial begin
    void'($urandom(77417));
    repeat (4) @(posedge sys_clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge sys_clk);
    run(8'h01, 16'h0001, 8'h00, 8'h00);
    run(8'hff, 16'h0002, 8'h01, 8'h01);
    // Hold lands after the window, during injection
    run(8'h80, 16'h0003, 8'h14, 8'h14);
    // Hold at the latest point still inside the window
    run(8'h03, 16'h0001, 8'h10, 8'h02);
    // Go with an empty mask is refused
    @(posedge sys_clk);
    chem_mask <= 8'h00;
    inject_go <= 1'b1;
    @(posedge sys_clk);
    inject_go <= 1'b0;
    #1 chk(inject_request, 0);
    repeat (6) run(8'($urandom_range(255, 1)), 16'($urandom_range(3, 1)),
      8'($urandom_range(10, 0)), 8'($urandom_range(15, 1)));
    end_sim();
  end
endmodule
`default_nettype wire
